// ### rtl/fbpdm_cfg.svh
// constants of the fieldbus process data map: offsets, fields, resets
`ifndef FBPDM_CFG_SVH
`define FBPDM_CFG_SVH

// ==========================================================
// wishbone register byte addresses
`define FBPDM_ADR_CONFIG 8'h00
`define FBPDM_ADR_STATUS 8'h04
`define FBPDM_ADR_OSEL 8'h08
`define FBPDM_ADR_ISEL 8'h30
`define FBPDM_ADR_END 8'h58

// ==========================================================
// config register fields and reset values
`define FBPDM_CFG_FMT_LSB 0
`define FBPDM_CFG_FAM_LSB 8
`define FBPDM_RST_FORMAT 3'h5
`define FBPDM_RST_FAMILY 8'h00
`define FBPDM_RST_SEL 16'h0000

// ==========================================================
// module formats and their word layout
`define FBPDM_FMT_1 3'h1
`define FBPDM_FMT_2 3'h2
`define FBPDM_FMT_3 3'h3
`define FBPDM_FMT_4 3'h4
`define FBPDM_FMT_5 3'h5
`define FBPDM_PKW_WORDS 4'h4
`define FBPDM_PZD_SHORT 4'h2
`define FBPDM_PZD_MID 4'h6
`define FBPDM_PZD_LONG 4'ha

// ==========================================================
// parameter messaging codes
`define FBPDM_AK_CLEAR 4'h0
`define FBPDM_AK_RD_ELEM 4'h6
`define FBPDM_AK_CHG_ELEM 4'h7
`define FBPDM_RSP_NONE 4'h0
`define FBPDM_RSP_ELEM_OK 4'h4
`define FBPDM_RSP_FAIL_PARM 4'h7
`define FBPDM_RSP_FAIL_ELEM 4'h8
`define FBPDM_PNU_OUT_SEL 11'h393
`define FBPDM_PNU_IN_SEL 11'h394
`define FBPDM_ERR_CODE 16'h0001

// ==========================================================
// control and status word bit positions
`define FBPDM_CW_RUN_EN 3
`define FBPDM_CW_RUN 4
`define FBPDM_CW_FAULT_RST 7
`define FBPDM_CW_JOG_FWD 8
`define FBPDM_CW_JOG_REV 9
`define FBPDM_CW_OVERRIDE 10
`define FBPDM_SW_MAINS 1
`define FBPDM_SW_READY 2
`define FBPDM_SW_FAULT 3
`define FBPDM_SW_ALARM 7
`define FBPDM_SW_ARRIVAL 8
`define FBPDM_SW_CTRL 9
`define FBPDM_SW_FIXED 16'h0031

// ==========================================================
// frequency scaling
`define FBPDM_HF_SCALE 20'h0000a
`define FBPDM_WORD_MAX 20'h07fff

`endif

// ### rtl/fbpdm_pkg.sv
// shared types of the fieldbus process data map
package fbpdm_pkg;
   typedef logic [15:0] fbpdm_word_t;
   typedef logic [19:0] fbpdm_freq_t;
endpackage

// ### rtl/fbpdm_top.sv
// fieldbus process data map: cyclic words to inverter registers
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fbpdm_cfg.svh"
module fbpdm_top
   import fbpdm_pkg::*;
#(
   parameter int NUM_PZD = 10
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // fieldbus output area, words from the master
   input wire logic fb_wr_i,
   input wire logic [3:0] fb_wr_idx_i,
   input wire logic [15:0] fb_wr_data_i,
   // fieldbus input area, words to the master
   input wire logic fb_rd_i,
   input wire logic [3:0] fb_rd_idx_i,
   output logic [15:0] fb_rd_data_o,
   output logic fb_rd_valid_o,
   // inverter register set
   output logic inv_wr_o,
   output logic [15:0] inv_wr_addr_o,
   output logic [15:0] inv_wr_data_o,
   output logic inv_rd_o,
   output logic [15:0] inv_rd_addr_o,
   input wire logic [15:0] inv_rd_data_i,
   // drive state
   input wire logic mains_on_i,
   input wire logic ready_i,
   input wire logic fault_i,
   input wire logic alarm_i,
   input wire logic freq_arrival_i,
   input wire logic fieldbus_src_i,
   input wire logic hf_mode_i,
   input wire logic out_reverse_i,
   input wire logic [19:0] out_freq_i,
   input wire logic [19:0] jog_freq_i,
   // drive commands
   output logic coast_stop_o,
   output logic run_o,
   output logic jog_fwd_o,
   output logic jog_rev_o,
   output logic bus_override_o,
   output logic fault_reset_o,
   output logic reverse_o,
   output logic [19:0] freq_cmd_o
);

   // ==========================================================
   // word decode: {pkw hit, pzd hit, pzd number}
   function automatic logic [5:0] decode(input logic [3:0] idx,
      input logic [2:0] fmt, input logic fam_ok);
      logic pkw;
      logic [3:0] npzd;
      logic [3:0] base;
      logic [3:0] rel;
      logic pzd;
      begin
         pkw = (fmt == `FBPDM_FMT_1) || (fmt == `FBPDM_FMT_2) ||
            (fmt == `FBPDM_FMT_5);
         unique case (fmt)
            `FBPDM_FMT_1, `FBPDM_FMT_3: npzd = `FBPDM_PZD_SHORT;
            `FBPDM_FMT_2, `FBPDM_FMT_4: npzd = `FBPDM_PZD_MID;
            `FBPDM_FMT_5: npzd = `FBPDM_PZD_LONG;
            default: npzd = 4'h0;
         endcase
         base = pkw ? `FBPDM_PKW_WORDS : 4'h0;
         rel = idx - base;
         pzd = fam_ok && (idx >= base) && (rel < npzd);
         decode = {fam_ok && pkw && (idx < `FBPDM_PKW_WORDS), pzd, rel};
      end
   endfunction

   // ==========================================================
   // state
   logic [2:0] cfg_format;
   logic [7:0] cfg_family;
   fbpdm_word_t sel_out [NUM_PZD];
   fbpdm_word_t sel_in [NUM_PZD];
   fbpdm_word_t pkw_out [4];
   fbpdm_word_t pkw_in [4];
   fbpdm_word_t ctrl_word;
   fbpdm_word_t setpoint;
   logic rd_pend;
   logic rd_use_inv;
   fbpdm_word_t rd_imm;

   // ==========================================================
   // wishbone decode
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr = wb_req && wb_we_i;
   wire wb_osel = (wb_adr_i >= `FBPDM_ADR_OSEL) &&
      (wb_adr_i < `FBPDM_ADR_ISEL) && (wb_adr_i[1:0] == 2'h0);
   wire wb_isel = (wb_adr_i >= `FBPDM_ADR_ISEL) &&
      (wb_adr_i < `FBPDM_ADR_END) && (wb_adr_i[1:0] == 2'h0);
   wire [7:0] wb_orel = wb_adr_i - `FBPDM_ADR_OSEL;
   wire [7:0] wb_irel = wb_adr_i - `FBPDM_ADR_ISEL;
   wire [3:0] wb_oidx = wb_orel[5:2];
   wire [3:0] wb_iidx = wb_irel[5:2];
   wire wb_cfg = wb_adr_i == `FBPDM_ADR_CONFIG;
   wire wb_stat = wb_adr_i == `FBPDM_ADR_STATUS;

   // ==========================================================
   // fieldbus write decode
   // family gate
   wire fam_ok = cfg_family == 8'h00;
   wire [5:0] wr_dec = decode(fb_wr_idx_i, cfg_format, fam_ok);
   wire wr_pkw = fb_wr_i && wr_dec[5];
   wire wr_pzd = fb_wr_i && wr_dec[4];
   wire [3:0] wr_num = wr_dec[3:0];
   wire [3:0] wr_sel_idx = (wr_num < NUM_PZD[3:0]) ? wr_num : 4'h0;
   wire fbpdm_word_t wr_osel = sel_out[wr_sel_idx];
   // control role only with both first selectors zero; setpoint role with the second output selector zero
   wire role_ctrl = (sel_out[0] == 16'h0000) && (sel_in[0] == 16'h0000);
   wire role_sp = sel_out[1] == 16'h0000;
   wire wr_inv = wr_pzd && (wr_osel != 16'h0000);
   wire wr_ctrl = wr_pzd && (wr_num == 4'h0) && !wr_inv && role_ctrl;
   wire wr_sp = wr_pzd && (wr_num == 4'h1) && !wr_inv;

   // ==========================================================
   // parameter task, committed on the low value word
   wire pkw_commit = wr_pkw && (fb_wr_idx_i == 4'h3);
   wire [3:0] ak = pkw_out[0][15:12];
   wire [10:0] parameter_number = pkw_out[0][10:0];
   wire [7:0] elem = pkw_out[1][15:8];
   wire pnu_osel = parameter_number == `FBPDM_PNU_OUT_SEL;
   wire pnu_isel = parameter_number == `FBPDM_PNU_IN_SEL;
   wire elem_ok = (elem >= 8'h01) && (elem <= NUM_PZD[7:0]);
   wire [7:0] elem_rel = elem - 8'h01;
   wire [3:0] elem_idx = elem_ok ? elem_rel[3:0] : 4'h0;
   wire task_elem = (ak == `FBPDM_AK_RD_ELEM) ||
      (ak == `FBPDM_AK_CHG_ELEM);
   wire task_ok = task_elem && (pnu_osel || pnu_isel) && elem_ok;
   wire pkw_chg = pkw_commit && task_ok && (ak == `FBPDM_AK_CHG_ELEM);
   wire pkw_chg_out = pkw_chg && pnu_osel;
   wire pkw_chg_in = pkw_chg && pnu_isel;
   wire fbpdm_word_t elem_val = pnu_osel ? sel_out[elem_idx] :
      sel_in[elem_idx];
   wire [3:0] next_rsp = (ak == `FBPDM_AK_CLEAR) ? `FBPDM_RSP_NONE :
      !(task_elem && (pnu_osel || pnu_isel)) ? `FBPDM_RSP_FAIL_PARM :
      !elem_ok ? `FBPDM_RSP_FAIL_ELEM : `FBPDM_RSP_ELEM_OK;
   wire fbpdm_word_t next_pval = (ak == `FBPDM_AK_CLEAR) ? 16'h0000 :
      !task_ok ? `FBPDM_ERR_CODE :
      (ak == `FBPDM_AK_CHG_ELEM) ? fb_wr_data_i : elem_val;

   // ==========================================================
   // config register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_format <= `FBPDM_RST_FORMAT;
         cfg_family <= `FBPDM_RST_FAMILY;
      end else if (wb_wr && wb_cfg) begin
         if (wb_sel_i[0])
            cfg_format <= wb_dat_i[`FBPDM_CFG_FMT_LSB +: 3];
         if (wb_sel_i[1])
            cfg_family <= wb_dat_i[`FBPDM_CFG_FAM_LSB +: 8];
      end
   end

   // ==========================================================
   // selectors per word; parameter task beats a same-cycle bus write
   for (genvar i = 0; i < NUM_PZD; i++) begin : g_sel
      wire wb_o = wb_wr && wb_osel && (wb_oidx == 4'(i));
      wire wb_i = wb_wr && wb_isel && (wb_iidx == 4'(i));
      wire pk_o = pkw_chg_out && (elem_idx == 4'(i));
      wire pk_i = pkw_chg_in && (elem_idx == 4'(i));
      wire fbpdm_word_t wb_o_val = {
         wb_sel_i[1] ? wb_dat_i[15:8] : sel_out[i][15:8],
         wb_sel_i[0] ? wb_dat_i[7:0] : sel_out[i][7:0]};
      wire fbpdm_word_t wb_i_val = {
         wb_sel_i[1] ? wb_dat_i[15:8] : sel_in[i][15:8],
         wb_sel_i[0] ? wb_dat_i[7:0] : sel_in[i][7:0]};
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sel_out[i] <= `FBPDM_RST_SEL;
            sel_in[i] <= `FBPDM_RST_SEL;
         end else begin
            if (pk_o)
               sel_out[i] <= fb_wr_data_i;
            else if (wb_o)
               sel_out[i] <= wb_o_val;
            if (pk_i)
               sel_in[i] <= fb_wr_data_i;
            else if (wb_i)
               sel_in[i] <= wb_i_val;
         end
      end
   end

   // ==========================================================
   // parameter messaging area storage and response
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < 4; k++) begin
            pkw_out[k] <= 16'h0000;
            pkw_in[k] <= 16'h0000;
         end
      end else begin
         if (wr_pkw)
            pkw_out[fb_wr_idx_i[1:0]] <= fb_wr_data_i;
         if (pkw_commit) begin
            pkw_in[0] <= {next_rsp, 1'b0, parameter_number};
            pkw_in[1] <= pkw_out[1];
            pkw_in[2] <= 16'h0000;
            pkw_in[3] <= next_pval;
         end
      end
   end

   // ==========================================================
   // control word and setpoint; dropped when their role is lost
   wire fbpdm_word_t next_ctrl = !role_ctrl ? 16'h0000 :
      wr_ctrl ? fb_wr_data_i : ctrl_word;
   wire fbpdm_word_t next_sp = !role_sp ? 16'h0000 :
      wr_sp ? fb_wr_data_i : setpoint;
   // fault reset only on a rising bit
   wire next_fault_rst = wr_ctrl && fb_wr_data_i[`FBPDM_CW_FAULT_RST] &&
      !ctrl_word[`FBPDM_CW_FAULT_RST];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_word <= 16'h0000;
         setpoint <= 16'h0000;
         fault_reset_o <= 1'b0;
      end else begin
         ctrl_word <= next_ctrl;
         setpoint <= next_sp;
         fault_reset_o <= next_fault_rst;
      end
   end

   // ==========================================================
   // drive commands from control word and setpoint
   // magnitude of the signed setpoint
   wire [16:0] sp_abs = setpoint[15] ? (17'h00000 - {1'b1, setpoint}) :
      {1'b0, setpoint};
   // HF mode counts in tenths of a hertz
   wire [19:0] sp_hz100 = hf_mode_i ?
      20'(sp_abs * `FBPDM_HF_SCALE) : {3'h0, sp_abs};
   wire jog_f = ctrl_word[`FBPDM_CW_JOG_FWD];
   wire jog_r = ctrl_word[`FBPDM_CW_JOG_REV];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         coast_stop_o <= 1'b1;
         run_o <= 1'b0;
         jog_fwd_o <= 1'b0;
         jog_rev_o <= 1'b0;
         bus_override_o <= 1'b0;
         reverse_o <= 1'b0;
         freq_cmd_o <= 20'h00000;
      end else begin
         coast_stop_o <= !ctrl_word[`FBPDM_CW_RUN_EN];
         run_o <= ctrl_word[`FBPDM_CW_RUN];
         jog_fwd_o <= jog_f;
         jog_rev_o <= jog_r;
         bus_override_o <= ctrl_word[`FBPDM_CW_OVERRIDE];
         // direction from sign, jog sets its own
         reverse_o <= jog_r ? 1'b1 : jog_f ? 1'b0 : setpoint[15];
         freq_cmd_o <= (jog_f || jog_r) ? jog_freq_i : sp_hz100;
      end
   end

   // ==========================================================
   // status word and output frequency word
   // fixed, drive and control bits
   wire fbpdm_word_t status_word = `FBPDM_SW_FIXED |
      (16'(mains_on_i) << `FBPDM_SW_MAINS) |
      (16'(ready_i) << `FBPDM_SW_READY) |
      (16'(fault_i) << `FBPDM_SW_FAULT) |
      (16'(alarm_i) << `FBPDM_SW_ALARM) |
      (16'(freq_arrival_i) << `FBPDM_SW_ARRIVAL) |
      (16'(ctrl_word[`FBPDM_CW_OVERRIDE] | fieldbus_src_i)
         << `FBPDM_SW_CTRL);
   // HF mode reports tenths of a hertz
   wire [19:0] of_scaled = hf_mode_i ? (out_freq_i / `FBPDM_HF_SCALE) :
      out_freq_i;
   // saturate rather than wrap into the sign bit
   wire [14:0] of_mag = (of_scaled > `FBPDM_WORD_MAX) ? 15'h7fff :
      of_scaled[14:0];
   wire fbpdm_word_t out_freq_word = out_reverse_i ?
      (16'h0000 - {1'b0, of_mag}) : {1'b0, of_mag};

   // ==========================================================
   // fieldbus read decode
   wire [5:0] rd_dec = decode(fb_rd_idx_i, cfg_format, fam_ok);
   wire rd_pkw = rd_dec[5];
   wire rd_pzd = rd_dec[4];
   wire [3:0] rd_num = rd_dec[3:0];
   wire [3:0] rd_sel_idx = (rd_num < NUM_PZD[3:0]) ? rd_num : 4'h0;
   wire fbpdm_word_t rd_isel = sel_in[rd_sel_idx];
   wire rd_inv = rd_pzd && (rd_isel != 16'h0000);
   wire rd_status = rd_pzd && (rd_num == 4'h0) && !rd_inv && role_ctrl;
   wire rd_freq = rd_pzd && (rd_num == 4'h1) && !rd_inv;
   // absent or unselected words read zero
   wire fbpdm_word_t next_imm = rd_pkw ? pkw_in[fb_rd_idx_i[1:0]] :
      rd_status ? status_word : rd_freq ? out_freq_word : 16'h0000;

   // ==========================================================
   // read pipeline: request, register fetch, answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_pend <= 1'b0;
         rd_use_inv <= 1'b0;
         rd_imm <= 16'h0000;
         inv_rd_o <= 1'b0;
         inv_rd_addr_o <= 16'h0000;
         fb_rd_valid_o <= 1'b0;
         fb_rd_data_o <= 16'h0000;
      end else begin
         rd_pend <= fb_rd_i;
         rd_use_inv <= fb_rd_i && rd_inv;
         rd_imm <= next_imm;
         inv_rd_o <= fb_rd_i && rd_inv;
         inv_rd_addr_o <= rd_isel;
         fb_rd_valid_o <= rd_pend;
         fb_rd_data_o <= rd_use_inv ? inv_rd_data_i : rd_imm;
      end
   end

   // ==========================================================
   // inverter register writes from output process words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inv_wr_o <= 1'b0;
         inv_wr_addr_o <= 16'h0000;
         inv_wr_data_o <= 16'h0000;
      end else begin
         // selector zero writes no inverter register
         inv_wr_o <= wr_inv;
         inv_wr_addr_o <= wr_osel;
         inv_wr_data_o <= fb_wr_data_i;
      end
   end

   // ==========================================================
   // wishbone read mux and ack; unmapped reads answer zero
   wire [31:0] wb_rdata = wb_cfg ?
      {16'h0000, cfg_family, 5'h00, cfg_format} :
      wb_stat ? {status_word, ctrl_word} :
      wb_osel ? {16'h0000, sel_out[wb_oidx]} :
      wb_isel ? {16'h0000, sel_in[wb_iidx]} : 32'h00000000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_rdata;
      end
   end

endmodule
`default_nettype wire

// ### sim/fbpdm_chk.sv
// concurrent checks on the fieldbus process data map ports
`timescale 1ns/1ps
`default_nettype none
module fbpdm_chk #(
   parameter int NUM_PZD = 10
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // fieldbus areas
   input wire logic fb_wr_i,
   input wire logic [15:0] fb_wr_data_i,
   input wire logic fb_rd_i,
   input wire logic fb_rd_valid_o,
   input wire logic [15:0] fb_rd_data_o,
   // inverter side and commands
   input wire logic inv_wr_o,
   input wire logic [15:0] inv_wr_data_o,
   input wire logic inv_rd_o,
   input wire logic [15:0] inv_rd_data_i,
   input wire logic fault_reset_o,
   input wire logic jog_rev_o,
   input wire logic reverse_o
);
   // ==========
   // one clock domain, reset masks everything
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // read request and its answer two cycles on
   sequence s_rd_req;
      fb_rd_i;
   endsequence
   sequence s_rd_ans;
      ##2 fb_rd_valid_o;
   endsequence
   // a wishbone request not yet answered
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (s_wb_req |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   rd_answer_a: assert property (s_rd_req |-> s_rd_ans)
      else $error("input word not returned on time");
   rd_cause_a: assert property (fb_rd_valid_o |-> $past(fb_rd_i, 2))
      else $error("input word without request");
   rd_data_a: assert property (inv_rd_o |=> fb_rd_valid_o &&
      fb_rd_data_o == $past(inv_rd_data_i))
      else $error("register value not carried");
   wr_cause_a: assert property (inv_wr_o |-> $past(fb_wr_i) &&
      inv_wr_data_o == $past(fb_wr_data_i))
      else $error("register write not from output word");
   fault_cause_a: assert property (fault_reset_o |-> $past(fb_wr_i) &&
      $past(fb_wr_data_i[7]))
      else $error("fault reset without bit 7");
   fault_pulse_a: assert property (fault_reset_o |=> !fault_reset_o)
      else $error("fault reset longer than a pulse");
   jog_dir_a: assert property (jog_rev_o |-> reverse_o)
      else $error("reverse jog not reversing");
endmodule
bind fbpdm_top fbpdm_chk #(.NUM_PZD(NUM_PZD)) u_chk (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .fb_wr_i, .fb_wr_data_i,
   .fb_rd_i, .fb_rd_valid_o, .fb_rd_data_o, .inv_wr_o, .inv_wr_data_o,
   .inv_rd_o, .inv_rd_data_i, .fault_reset_o, .jog_rev_o, .reverse_o
);
`default_nettype wire

// ### sim/fbpdm_inv_model.sv
// behavioural inverter register set behind the process data map
`timescale 1ns/1ps
`default_nettype none
module fbpdm_inv_model (
   // clock
   input wire logic clk_i,
   // register writes
   input wire logic inv_wr_i,
   input wire logic [15:0] inv_wr_addr_i,
   input wire logic [15:0] inv_wr_data_i,
   // register reads
   input wire logic inv_rd_i,
   input wire logic [15:0] inv_rd_addr_i,
   output logic [15:0] inv_rd_data_o
);
   logic [15:0] mem [0:255];
   logic [15:0] last;
   // nonzero contents so a stray read never looks like a zero word
   initial begin
      last = 16'h0000;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'(i) ^ 16'h5a5a;
      end
   end
   // only the low address byte is decoded; the bench's addresses all carry high byte 01
   always @(posedge clk_i) begin
      if (inv_wr_i) begin
         mem[inv_wr_addr_i[7:0]] <= inv_wr_data_i;
      end
      if (inv_rd_i) begin
         last <= mem[inv_rd_addr_i[7:0]];
      end
   end
   // data valid only in the read cycle, scrambled otherwise
   assign inv_rd_data_o = inv_rd_i ? mem[inv_rd_addr_i[7:0]] : ~last;
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the fieldbus process data map
`timescale 1ns/1ps
`default_nettype none
`include "fbpdm_cfg.svh"
`define CHK(g, e) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); \
   end \
end
module tb;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, fb_wr_idx_i, fb_rd_idx_i;
   logic [31:0] wb_dat_i, wb_dat_o, q32;
   logic fb_wr_i, fb_rd_i, fb_rd_valid_o, inv_wr_o, inv_rd_o;
   logic [15:0] fb_wr_data_i, fb_rd_data_o, inv_wr_addr_o, inv_wr_data_o;
   logic [15:0] inv_rd_addr_o, inv_rd_data_i, q, d, a, sp, cw, ra, mag;
   logic mains_on_i, ready_i, fault_i, alarm_i, freq_arrival_i;
   logic fieldbus_src_i, hf_mode_i, out_reverse_i, fault_reset_o, reverse_o;
   logic coast_stop_o, run_o, jog_fwd_o, jog_rev_o, bus_override_o;
   logic [19:0] out_freq_i, jog_freq_i, freq_cmd_o;
   int seed, n_mismatch, n_tests, cycles, b, w;
   // parameter task table: {word0, element, value, response, answer}
   logic [59:0] pk [5] = '{{16'h7393, 8'h04, 16'h1234, 4'h4, 16'h1234},
      {16'h6393, 8'h04, 16'h0000, 4'h4, 16'h1234},
      {16'h7394, 8'h0a, 16'h00aa, 4'h4, 16'h00aa},
      {16'h6393, 8'h0b, 16'h0000, 4'h8, 16'h0001},
      {16'h6100, 8'h01, 16'h0000, 4'h7, 16'h0001}};
   fbpdm_top u_fbpdm_top (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .fb_wr_i, .fb_wr_idx_i, .fb_wr_data_i,
      .fb_rd_i, .fb_rd_idx_i, .fb_rd_data_o, .fb_rd_valid_o, .inv_wr_o,
      .inv_wr_addr_o, .inv_wr_data_o, .inv_rd_o, .inv_rd_addr_o,
      .inv_rd_data_i, .mains_on_i, .ready_i, .fault_i, .alarm_i,
      .freq_arrival_i, .fieldbus_src_i, .hf_mode_i, .out_reverse_i,
      .out_freq_i, .jog_freq_i, .coast_stop_o, .run_o, .jog_fwd_o,
      .jog_rev_o, .bus_override_o, .fault_reset_o, .reverse_o, .freq_cmd_o
   );
   fbpdm_inv_model u_fbpdm_inv_model (
      .clk_i, .inv_wr_i(inv_wr_o), .inv_wr_addr_i(inv_wr_addr_o),
      .inv_wr_data_i(inv_wr_data_o), .inv_rd_i(inv_rd_o),
      .inv_rd_addr_i(inv_rd_addr_o), .inv_rd_data_o(inv_rd_data_i)
   );
   // ==========
   // clock and hang guard
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   // ==========
   // reference model of the status and frequency words
   function automatic logic [15:0] sw_exp();
      return 16'h0031 | {6'h00, cw[10] | fieldbus_src_i, freq_arrival_i,
         alarm_i, 3'h0, fault_i, ready_i, mains_on_i, 1'b0};
   endfunction
   function automatic logic [15:0] hiw_exp();
      int m;
      m = out_freq_i / (hf_mode_i ? 10 : 1);
      if (m > 32767) m = 32767;
      return out_reverse_i ? 16'(-m) : 16'(m);
   endfunction
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] ad,
      input logic [31:0] v, output logic [31:0] r);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hf;
      wb_adr_i <= ad;
      wb_dat_i <= v;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] v);
      wb(1'b1, ad, v, q32);
   endtask
   // one output word; the data lines are scrambled after release
   task automatic fbw(input logic [3:0] i, input logic [15:0] v);
      fb_wr_i <= 1'b1;
      fb_wr_idx_i <= i;
      fb_wr_data_i <= v;
      @(posedge clk_i);
      fb_wr_i <= 1'b0;
      fb_wr_data_i <= ~v;
      @(posedge clk_i);
   endtask
   task automatic fbr(input logic [3:0] i, output logic [15:0] r);
      fb_rd_i <= 1'b1;
      fb_rd_idx_i <= i;
      @(posedge clk_i);
      fb_rd_i <= 1'b0;
      @(posedge clk_i);
      ra = inv_rd_o ? inv_rd_addr_o : 16'h0000;
      @(posedge clk_i);
      `CHK(fb_rd_valid_o, 1'b1)
      r = fb_rd_data_o;
   endtask
   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========
   // main sequence
   initial begin
      seed = 32'h0042ae70;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, cw} = '0;
      {fb_wr_i, fb_rd_i, fb_wr_idx_i, fb_rd_idx_i, fb_wr_data_i} = '0;
      {out_freq_i, jog_freq_i, mains_on_i, ready_i, fault_i} = '0;
      {alarm_i, freq_arrival_i, fieldbus_src_i, hf_mode_i} = '0;
      out_reverse_i = 1'b0;
      wb_sel_i = 4'hf;
      rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, `FBPDM_ADR_CONFIG, 32'h00000000, q32);
      `CHK(q32, 32'h00000005)
      wb(1'b0, `FBPDM_ADR_STATUS, 32'h00000000, q32);
      `CHK(q32, {sw_exp(), cw})
      wr(`FBPDM_ADR_END, 32'hffffffff);
      wb(1'b0, `FBPDM_ADR_END, 32'h00000000, q32);
      `CHK(q32, 32'h00000000)
      // random control, setpoint and drive state
      repeat (6) begin
         {mains_on_i, ready_i, fault_i, alarm_i, freq_arrival_i,
            fieldbus_src_i, hf_mode_i, out_reverse_i} <= 8'($random(seed));
         out_freq_i <= 20'($random(seed));
         jog_freq_i <= 20'($random(seed));
         d = 16'($random(seed));
         fbw(4'h4, d);
         `CHK(fault_reset_o, d[7] & ~cw[7])
         cw = d;
         sp = 16'($random(seed));
         mag = sp[15] ? 16'h0000 - sp : sp;
         fbw(4'h5, sp);
         @(posedge clk_i);
         `CHK({coast_stop_o, run_o}, {~cw[3], cw[4]})
         `CHK({jog_rev_o, jog_fwd_o}, cw[9:8])
         `CHK(bus_override_o, cw[10])
         if (cw[9:8] != 2'b00) begin
            `CHK(freq_cmd_o, jog_freq_i)
         end else begin
            `CHK(reverse_o, sp[15])
            `CHK(freq_cmd_o, mag * (hf_mode_i ? `FBPDM_HF_SCALE : 1))
         end
         fbr(4'h4, q);
         `CHK(q, sw_exp())
         fbr(4'h5, q);
         `CHK(q, hiw_exp())
      end
      // formats: word offsets and absent words
      wr(`FBPDM_ADR_ISEL + 8'h08, 32'h00000001);
      for (int f = 1; f <= 5; f++) begin
         wr(`FBPDM_ADR_CONFIG, 32'(f));
         b = (f == 3 || f == 4) ? 0 : 4;
         w = (f == 2 || f == 4) ? 6 : (f == 5) ? 10 : 2;
         cw = {11'h000, f[0], 4'h8};
         fbw(4'(b), cw);
         @(posedge clk_i);
         `CHK(run_o, cw[4])
         fbr(4'(b + 1), q);
         `CHK(q, hiw_exp())
         fbr(4'(b + w), q);
         `CHK(q, 16'h0000)
      end
      wr(`FBPDM_ADR_CONFIG, 32'h00000105);
      fbw(4'h4, 16'h0008);
      @(posedge clk_i);
      `CHK(run_o, 1'b1)
      wr(`FBPDM_ADR_CONFIG, 32'h00000005);
      // every process word through its selectors
      for (int n = 1; n <= 10; n++) begin
         a = {8'h01, 8'($random(seed))};
         d = 16'($random(seed));
         wr(8'(`FBPDM_ADR_OSEL + 4 * (n - 1)), {16'h0000, a});
         wr(8'(`FBPDM_ADR_ISEL + 4 * (n - 1)), {16'h0000, a});
         fbw(4'(n + 3), d);
         if (n == 1) `CHK(run_o, 1'b0)
         `CHK({inv_wr_o, inv_wr_addr_o, inv_wr_data_o}, {1'b1, a, d})
         fbr(4'(n + 3), q);
         `CHK({ra, q}, {a, d})
         wr(8'(`FBPDM_ADR_ISEL + 4 * (n - 1)), 32'h00000000);
         fbr(4'(n + 3), q);
         `CHK(q, (n == 2) ? hiw_exp() : 16'h0000)
         wr(8'(`FBPDM_ADR_OSEL + 4 * (n - 1)), 32'h00000000);
         fbw(4'(n + 3), d);
         `CHK(inv_wr_o, 1'b0)
      end
      // parameter messaging tasks on the selector arrays
      for (int k = 0; k < 5; k++) begin
         fbw(4'h0, pk[k][59:44]);
         fbw(4'h1, {pk[k][43:36], 8'h00});
         fbw(4'h2, 16'h0000);
         fbw(4'h3, pk[k][35:20]);
         fbr(4'h0, q);
         `CHK(q, {pk[k][19:16], 1'b0, pk[k][54:44]})
         fbr(4'h3, q);
         `CHK(q, pk[k][15:0])
      end
      wb(1'b0, `FBPDM_ADR_OSEL + 8'h0c, 32'h00000000, q32);
      `CHK(q32, 32'h00001234)
      wb(1'b0, `FBPDM_ADR_ISEL + 8'h24, 32'h00000000, q32);
      `CHK(q32, 32'h000000aa)
      summarize();
   end
endmodule
`default_nettype wire
